//--- shared/memmap_pkg.sv
// Functional notes
// - X addresses 0 to 255 select the internal X data RAM, 24 bits wide.
// - Y addresses 0 to 255 select the separate internal Y data RAM.
// - X addresses 256 to 511 select the X data ROM when data ROM is enabled.
// - Y addresses 256 to 511 select the Y data ROM under the same enable.
// - Top 64 X locations select the on-chip peripheral registers.
// - Peripheral register accesses in X never appear on the external port.
// - X space uses 16-bit addresses, 24-bit data, expandable to 64K words.
// - Y space uses 16-bit addresses, 24-bit data, expandable to 64K words.
// - Internal program ROM is 3840 by 24, enabled by the two mode bits.
// - With program ROM disabled, fetches go off-chip; the mode-one ROM is never selected.
// - Program addresses from program bus; off-chip program memory accepts moves.
// - Lowest 64 program locations hold the on-chip interrupt vectors.
// - Mode pins are sampled as reset is left and set the initial mode.
// - After reset the mode pins serve only as external interrupt requests.
// - Pins 00 and 01 single-chip, 10 normal expanded, 11 development.
// - Software writes to mode bits change mode at once, no reset.
// - Single-chip mode enables internal program ROM; data ROM follows its own enable bit.
// - Reset vector is 0000 in mode 0, E000 in mode 2; maps otherwise equal.
// - Mode 1 behaves exactly like mode 0.
// - Development mode disables internal program memory; all fetches external.
// - Secured variant forces single-chip mode at reset and power-up.
// - Secured variant pins are interrupt inputs only, never change the mode.
package memmap_pkg;

  localparam int          ADDR_W        = 16;
  localparam int          DATA_W        = 24;
  localparam logic [15:0] DRAM_LAST     = 16'h00FF;
  localparam logic [15:0] DROM_FIRST    = 16'h0100;
  localparam logic [15:0] DROM_LAST     = 16'h01FF;
  localparam logic [15:0] PERIPH_FIRST  = 16'hFFC0;
  localparam logic [15:0] PROM_LAST     = 16'h0EFF;
  localparam logic [15:0] VECTOR_LAST   = 16'h003F;
  localparam logic [15:0] RESET_VEC_M0  = 16'h0000;
  localparam logic [15:0] RESET_VEC_M2  = 16'hE000;

  // Register map over APB (byte addresses).
  localparam logic [11:0] MODE_REG_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET   = 12'h004;
  localparam int          MODE_LOW_POS    = 0;
  localparam int          MODE_HIGH_POS   = 1;
  localparam int          DROM_EN_POS     = 2;
  localparam logic [2:0]  MODE_REG_RESET  = 3'h0;

  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_SINGLE_ALT,
    MODE_EXPANDED,
    MODE_DEVELOP
  } op_mode_t;

  typedef enum logic [2:0] {
    TGT_RAM,
    TGT_DROM,
    TGT_PERIPH,
    TGT_PROM,
    TGT_MODE1_ROM,
    TGT_EXTERNAL
  } target_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
  } mem_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [1:0]  space;
    logic [15:0] addr;
  } ext_req_t;

  localparam logic [1:0] SPACE_P = 2'h0;
  localparam logic [1:0] SPACE_X = 2'h1;
  localparam logic [1:0] SPACE_Y = 2'h2;

endpackage : memmap_pkg

//--- src/data_space_decode.sv
`timescale 1ns/1ps
// Decodes one data space (X or Y) address to its target.
module data_space_decode #(
  parameter bit HAS_PERIPH = 1'b1
) (
  input  wire memmap_pkg::mem_req_t req,
  input  wire logic                 rom_en,
  output memmap_pkg::target_t       target
);
  import memmap_pkg::*;

  // Priority: peripherals, RAM, enabled data ROM, else the external port.
  always_comb
  begin
    if (HAS_PERIPH && req.addr >= PERIPH_FIRST)
      target = TGT_PERIPH;
    else if (req.addr <= DRAM_LAST)
      target = TGT_RAM;
    else if (rom_en && req.addr >= DROM_FIRST && req.addr <= DROM_LAST)
      target = TGT_DROM;
    else
      target = TGT_EXTERNAL;
  end

endmodule : data_space_decode

//--- src/prog_space_decode.sv
`timescale 1ns/1ps
// Decodes a program-space address according to the operating mode.
module prog_space_decode (
  input  wire memmap_pkg::mem_req_t req,
  input  wire memmap_pkg::op_mode_t mode,
  output memmap_pkg::target_t       target
);
  import memmap_pkg::*;

  // Internal ROM serves reads below its end unless in development mode.
  always_comb
  begin
    case (mode)
      MODE_SINGLE, MODE_SINGLE_ALT, MODE_EXPANDED:
        target = (!req.write && req.addr <= PROM_LAST) ? TGT_PROM : TGT_EXTERNAL;
      MODE_DEVELOP:
        target = TGT_EXTERNAL;
      default:
        target = TGT_EXTERNAL;
    endcase
  end

endmodule : prog_space_decode

//--- src/memory_map_mode_decoder.sv
`timescale 1ns/1ps
// Memory-map and operating-mode logic with an APB view of the mode register.
module memory_map_mode_decoder #(
  parameter bit SECURED = 1'b0
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    mode_pin_low,
  input  wire logic                    mode_pin_high,
  output logic                         ext_irq_first,
  output logic                         ext_irq_second,
  input  wire memmap_pkg::mem_req_t    x_req,
  input  wire memmap_pkg::mem_req_t    y_req,
  input  wire memmap_pkg::mem_req_t    p_req,
  input  wire logic                    prog_mem_move,
  output memmap_pkg::target_t          x_target_q,
  output memmap_pkg::target_t          y_target_q,
  output memmap_pkg::target_t          p_target_q,
  output memmap_pkg::ext_req_t         ext_req_q,
  output logic                         vector_fetch_q,
  output logic      [15:0]             reset_vector_q,
  output logic                         mode1_rom_sel_q
);
  import memmap_pkg::*;

  logic                mode_bit_low_q;
  logic                mode_bit_high_q;
  logic                data_rom_enable_q;
  logic                out_of_reset_q;
  op_mode_t            mode;
  target_t             x_tgt;
  target_t             y_tgt;
  target_t             p_tgt;
  mem_req_t            p_req_eff;
  logic                wr_en;
  logic                rd_en;
  logic                addr_ok;

  // Decodes a byte address into a register hit by exact match.
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] off);
    reg_hit = (a == off);
  endfunction : reg_hit

  assign mode = op_mode_t'({mode_bit_high_q, mode_bit_low_q});

  // Mode pins are interrupt requests from the first clock after reset release onward.
  assign ext_irq_first  = out_of_reset_q & mode_pin_low;
  assign ext_irq_second = out_of_reset_q & mode_pin_high;

  // APB strobes and address check.
  assign addr_ok = reg_hit(paddr, MODE_REG_OFFSET) || reg_hit(paddr, STATUS_OFFSET);
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Marks the first clock after reset release.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_of_reset_q <= 1'b0;
    else
      out_of_reset_q <= 1'b1;
  end

  // Mode bits: latched from pins (zeros when SECURED) at the first edge after release, then by software.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_bit_low_q  <= MODE_REG_RESET[MODE_LOW_POS];
      mode_bit_high_q <= MODE_REG_RESET[MODE_HIGH_POS];
    end
    else if (!out_of_reset_q)
    begin
      mode_bit_low_q  <= SECURED ? 1'b0 : mode_pin_low;
      mode_bit_high_q <= SECURED ? 1'b0 : mode_pin_high;
    end
    else if (wr_en && reg_hit(paddr, MODE_REG_OFFSET))
    begin
      mode_bit_low_q  <= pwdata[MODE_LOW_POS];
      mode_bit_high_q <= pwdata[MODE_HIGH_POS];
    end
  end

  // Data ROM enable bit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      data_rom_enable_q <= MODE_REG_RESET[DROM_EN_POS];
    else if (wr_en && reg_hit(paddr, MODE_REG_OFFSET))
      data_rom_enable_q <= pwdata[DROM_EN_POS];
  end

  // Read data is registered in the setup cycle, ready in the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0;
    else if (rd_en)
    begin
      if (reg_hit(paddr, MODE_REG_OFFSET))
        prdata <= {29'h0, data_rom_enable_q, mode_bit_high_q, mode_bit_low_q};
      else if (reg_hit(paddr, STATUS_OFFSET))
        prdata <= {26'h0, ext_irq_second, ext_irq_first, 1'b0, mode1_rom_sel_q,
                   mode_bit_high_q, mode_bit_low_q};
      else
        prdata <= 32'h0;
    end
  end

  // Program-memory moves are writes to program space.
  always_comb
  begin
    p_req_eff       = p_req;
    p_req_eff.write = p_req.write | prog_mem_move;
  end

  data_space_decode #(.HAS_PERIPH(1'b1)) u_x_dec (
    .req    (x_req),
    .rom_en (data_rom_enable_q),
    .target (x_tgt)
  );

  data_space_decode #(.HAS_PERIPH(1'b0)) u_y_dec (
    .req    (y_req),
    .rom_en (data_rom_enable_q),
    .target (y_tgt)
  );

  prog_space_decode u_p_dec (
    .req    (p_req_eff),
    .mode   (mode),
    .target (p_tgt)
  );

  // Registered targets for each space.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      x_target_q <= TGT_EXTERNAL;
      y_target_q <= TGT_EXTERNAL;
      p_target_q <= TGT_EXTERNAL;
    end
    else
    begin
      x_target_q <= x_tgt;
      y_target_q <= y_tgt;
      p_target_q <= p_tgt;
    end
  end

  // External port: program first, then X, then Y; peripherals never forwarded.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ext_req_q <= '0;
    else if (p_req_eff.valid && p_tgt == TGT_EXTERNAL)
      ext_req_q <= '{1'b1, p_req_eff.write, SPACE_P, p_req_eff.addr};
    else if (x_req.valid && x_tgt == TGT_EXTERNAL)
      ext_req_q <= '{1'b1, x_req.write, SPACE_X, x_req.addr};
    else if (y_req.valid && y_tgt == TGT_EXTERNAL)
      ext_req_q <= '{1'b1, y_req.write, SPACE_Y, y_req.addr};
    else
      ext_req_q <= '0;
  end

  // Vector-area fetch flag, reset vector and mode-one ROM indication.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      vector_fetch_q  <= 1'b0;
      reset_vector_q  <= RESET_VEC_M0;
      mode1_rom_sel_q <= 1'b0;
    end
    else
    begin
      vector_fetch_q  <= p_req.valid && p_req.addr <= VECTOR_LAST;
      reset_vector_q  <= (mode == MODE_EXPANDED) ? RESET_VEC_M2 : RESET_VEC_M0;
      mode1_rom_sel_q <= 1'b0;
    end
  end

  property p_periph_not_external;
    @(posedge pclk) disable iff (!presetn)
      (x_req.valid && x_req.addr >= PERIPH_FIRST && !(p_req_eff.valid && p_tgt == TGT_EXTERNAL))
      |=> !(ext_req_q.valid && ext_req_q.space == SPACE_X);
  endproperty
  a_periph_not_external: assert property (p_periph_not_external)
    else $error("Peripheral access reached the external port.");

  property p_xram;
    @(posedge pclk) disable iff (!presetn)
      (x_req.addr <= DRAM_LAST) |=> (x_target_q == TGT_RAM);
  endproperty
  a_xram: assert property (p_xram)
    else $error("Low X address did not select RAM.");

  property p_yram;
    @(posedge pclk) disable iff (!presetn)
      (y_req.addr <= DRAM_LAST) |=> (y_target_q == TGT_RAM);
  endproperty
  a_yram: assert property (p_yram)
    else $error("Low Y address did not select RAM.");

  property p_xrom;
    @(posedge pclk) disable iff (!presetn)
      (x_req.addr >= DROM_FIRST && x_req.addr <= DROM_LAST)
      |=> (x_target_q == (($past(data_rom_enable_q)) ? TGT_DROM : TGT_EXTERNAL));
  endproperty
  a_xrom: assert property (p_xrom)
    else $error("X data ROM decode wrong.");

  property p_yrom_off;
    @(posedge pclk) disable iff (!presetn)
      (!data_rom_enable_q && y_req.addr >= DROM_FIRST && y_req.addr <= DROM_LAST)
      |=> (y_target_q == TGT_EXTERNAL);
  endproperty
  a_yrom_off: assert property (p_yrom_off)
    else $error("Disabled Y data ROM still selected.");

  property p_dev_external;
    @(posedge pclk) disable iff (!presetn)
      (mode == MODE_DEVELOP) |=> (p_target_q == TGT_EXTERNAL);
  endproperty
  a_dev_external: assert property (p_dev_external)
    else $error("Development mode used internal program memory.");

  property p_reset_vec;
    @(posedge pclk) disable iff (!presetn)
      (mode == MODE_EXPANDED) ##1 (mode == MODE_EXPANDED) |-> (reset_vector_q == RESET_VEC_M2);
  endproperty
  a_reset_vec: assert property (p_reset_vec)
    else $error("Reset vector wrong in mode 2.");

  property p_sw_mode;
    @(posedge pclk) disable iff (!presetn)
      (out_of_reset_q && wr_en && paddr == MODE_REG_OFFSET)
      |=> ({mode_bit_high_q, mode_bit_low_q} == $past(pwdata[1:0]));
  endproperty
  a_sw_mode: assert property (p_sw_mode)
    else $error("Mode write did not take effect.");

  property p_strap;
    @(posedge pclk) disable iff (!presetn)
      (!out_of_reset_q && !SECURED)
      |=> ({mode_bit_high_q, mode_bit_low_q} == $past({mode_pin_high, mode_pin_low}));
  endproperty
  a_strap: assert property (p_strap)
    else $error("Mode pins not latched at reset exit.");

  property p_secure;
    @(posedge pclk) disable iff (!presetn)
      (!out_of_reset_q && SECURED) |=> (mode == MODE_SINGLE);
  endproperty
  a_secure: assert property (p_secure)
    else $error("Secured variant left single-chip mode at reset.");

  property p_xperiph;
    @(posedge pclk) disable iff (!presetn)
      (x_req.addr >= PERIPH_FIRST) |=> (x_target_q == TGT_PERIPH);
  endproperty
  a_xperiph: assert property (p_xperiph)
    else $error("Top X address did not select the peripherals.");

  property p_yperiph_ext;
    @(posedge pclk) disable iff (!presetn)
      (y_req.addr >= PERIPH_FIRST) |=> (y_target_q == TGT_EXTERNAL);
  endproperty
  a_yperiph_ext: assert property (p_yperiph_ext)
    else $error("Top Y address was not sent to the external port.");

  property p_yrom_on;
    @(posedge pclk) disable iff (!presetn)
      (data_rom_enable_q && y_req.addr >= DROM_FIRST && y_req.addr <= DROM_LAST)
      |=> (y_target_q == TGT_DROM);
  endproperty
  a_yrom_on: assert property (p_yrom_on)
    else $error("Enabled Y data ROM not selected.");

  property p_prom_read;
    @(posedge pclk) disable iff (!presetn)
      (mode != MODE_DEVELOP && !p_req_eff.write && p_req_eff.addr <= PROM_LAST)
      |=> (p_target_q == TGT_PROM);
  endproperty
  a_prom_read: assert property (p_prom_read)
    else $error("Internal program ROM not selected for a fetch.");

  property p_prog_write_ext;
    @(posedge pclk) disable iff (!presetn)
      p_req_eff.write |=> (p_target_q == TGT_EXTERNAL);
  endproperty
  a_prog_write_ext: assert property (p_prog_write_ext)
    else $error("Program write did not go to the external port.");

  property p_vector;
    @(posedge pclk) disable iff (!presetn)
      (p_req.valid && p_req.addr <= VECTOR_LAST) |=> vector_fetch_q;
  endproperty
  a_vector: assert property (p_vector)
    else $error("Vector area fetch not flagged.");

  property p_mode1_same;
    @(posedge pclk) disable iff (!presetn)
      (mode == MODE_SINGLE_ALT) |=> (reset_vector_q == RESET_VEC_M0 && !mode1_rom_sel_q);
  endproperty
  a_mode1_same: assert property (p_mode1_same)
    else $error("Mode 1 did not behave as mode 0.");

  property p_irq_pins;
    @(posedge pclk) disable iff (!presetn)
      out_of_reset_q |-> (ext_irq_first == mode_pin_low && ext_irq_second == mode_pin_high);
  endproperty
  a_irq_pins: assert property (p_irq_pins)
    else $error("Mode pins not passed on as interrupt requests.");

  property p_ext_x;
    @(posedge pclk) disable iff (!presetn)
      (x_req.valid && x_tgt == TGT_EXTERNAL && !(p_req_eff.valid && p_tgt == TGT_EXTERNAL))
      |=> (ext_req_q.valid && ext_req_q.space == SPACE_X
           && ext_req_q.addr == $past(x_req.addr));
  endproperty
  a_ext_x: assert property (p_ext_x)
    else $error("Unclaimed X access not forwarded.");

endmodule : memory_map_mode_decoder

//--- verification/core_bus_model.sv
`timescale 1ns/1ps
// Core side of the decoder: presents the three address buses and the move strobe.
module core_bus_model (
  input  wire logic            pclk,
  output memmap_pkg::mem_req_t x_req,
  output memmap_pkg::mem_req_t y_req,
  output memmap_pkg::mem_req_t p_req,
  output logic                 prog_mem_move
);
  import memmap_pkg::*;
  // Buses start idle.
  initial
  begin
    x_req = '0;
    y_req = '0;
    p_req = '0;
    prog_mem_move = 1'b0;
  end
  // Presents one request set just after a rising edge and holds it.
  task automatic send(input mem_req_t x, input mem_req_t y, input mem_req_t p, input logic mv);
    @(posedge pclk);
    x_req <= x;
    y_req <= y;
    p_req <= p;
    prog_mem_move <= mv;
  endtask : send
endmodule : core_bus_model

//--- verification/memory_map_mode_decoder_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the memory map and operating mode decoder.
module memory_map_mode_decoder_tb;
  import memmap_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pin_lo, pin_hi, mv, irq1, irq2, vf, m1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, rs;
  logic [15:0] rv, srv;
  logic        e;
  mem_req_t    xr, yr, pr;
  target_t     xt, yt, pt, spt;
  ext_req_t    er;
  int          err_total, num_checks, md, de, xa, ya, pa, pw, xw, yw, mvv, nl, nh;
  int          q[$];

  memory_map_mode_decoder i_memory_map_mode_decoder (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mode_pin_low(pin_lo),
    .mode_pin_high(pin_hi), .ext_irq_first(irq1), .ext_irq_second(irq2), .x_req(xr),
    .y_req(yr), .p_req(pr), .prog_mem_move(mv), .x_target_q(xt), .y_target_q(yt),
    .p_target_q(pt), .ext_req_q(er), .vector_fetch_q(vf), .reset_vector_q(rv),
    .mode1_rom_sel_q(m1));
  // Secured variant shares pins, buses and APB wires; its select stays low.
  memory_map_mode_decoder #(.SECURED(1'b1)) i_sec (.pclk(pclk), .presetn(presetn),
    .psel(1'b0), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(), .pready(), .pslverr(), .mode_pin_low(pin_lo), .mode_pin_high(pin_hi),
    .ext_irq_first(), .ext_irq_second(), .x_req(xr), .y_req(yr), .p_req(pr),
    .prog_mem_move(mv), .x_target_q(), .y_target_q(), .p_target_q(spt), .ext_req_q(),
    .vector_fetch_q(), .reset_vector_q(srv), .mode1_rom_sel_q());
  core_bus_model i_core_bus_model (.pclk(pclk), .x_req(xr), .y_req(yr), .p_req(pr),
    .prog_mem_move(mv));

  // Clock at 50 ns period.
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Xorshift source for addresses, modes and pins.
  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  // Picks a boundary address half of the time, any address otherwise.
  function automatic int pick();
    int tb[11] = '{'h00FF, 'h0100, 'h01FF, 'h0200, 'hFFBF, 'hFFC0, 'hFFFF, 'h0EFF,
                   'h0F00, 'h003F, 'h0040};
    if (xs() % 2)
      return tb[xs() % 11];
    return xs() % 65536;
  endfunction : pick

  // Reference decode: sp 0 program, 1 X, 2 Y.
  function automatic int exp_t(int sp, int a, int m, int d, int w);
    if (sp == 0)
      return (m == 3 || w != 0 || a > 'h0EFF) ? TGT_EXTERNAL : TGT_PROM;
    if (a <= 'h00FF)
      return TGT_RAM;
    if (a <= 'h01FF && d != 0)
      return TGT_DROM;
    if (sp == 1 && a >= 'hFFC0)
      return TGT_PERIPH;
    return TGT_EXTERNAL;
  endfunction : exp_t

  // Compares one observed value against its expectation.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Prints counts and verdict, then ends the run.
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // One APB transfer; waits on pready under a bound.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic se);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    se = pslverr;
    if (n >= 20)
    begin
      err_total++;
      complete_run();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Resets with the given strap levels held through the release.
  task automatic do_reset(input int m);
    @(posedge pclk);
    presetn <= 1'b0;
    pin_lo <= m[0];
    pin_hi <= m[1];
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
  endtask : do_reset

  // Main sequence: straps, refused access, then random decode traffic.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_lo = 1'b0;
    pin_hi = 1'b0;
    rs = 32'h782087DD;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i);
      chk("reset_vector", rv, (i == 2) ? 32'h0000E000 : 32'h0);
      chk("sec_vector", srv, 32'h0);
      apb(1'b0, 12'h004, 32'h0, rd, e);
      chk("status", rd, i | ((i & 1) << 4) | ((i >> 1) << 5));
    end
    $display("test straps done");
    apb(1'b1, 12'h008, 32'hFFFFFFFF, rd, e);
    chk("slverr", e, 1);
    apb(1'b0, 12'h008, 32'h0, rd, e);
    chk("unmapped_read", rd, 0);
    apb(1'b0, 12'h000, 32'h0, rd, e);
    chk("op_mode_reg_kept", rd, 3);
    $display("test refused done");
    md = 3;
    de = 0;
    for (int k = 0; k < 300; k++)
    begin
      if (k % 16 == 0)
      begin
        md = xs() % 4;
        de = xs() % 2;
        apb(1'b1, 12'h000, (de << 2) | md, rd, e);
        apb(1'b0, 12'h000, 32'h0, rd, e);
        chk("op_mode_reg", rd, (de << 2) | md);
      end
      xa = pick();
      ya = pick();
      pa = pick();
      xw = xs() % 2;
      yw = xs() % 2;
      pw = xs() % 2;
      mvv = (xs() % 4 == 0);
      nl = xs() % 2;
      nh = xs() % 2;
      i_core_bus_model.send({1'b1, xw[0], xa[15:0]}, {1'b1, yw[0], ya[15:0]},
                            {1'b1, pw[0], pa[15:0]}, mvv[0]);
      pin_lo <= nl[0];
      pin_hi <= nh[0];
      @(posedge pclk);
      #1;
      chk("x_target", xt, exp_t(1, xa, md, de, 0));
      chk("y_target", yt, exp_t(2, ya, md, de, 0));
      chk("p_target", pt, exp_t(0, pa, md, de, pw | mvv));
      chk("sec_p_target", spt, exp_t(0, pa, 0, 0, pw | mvv));
      q.delete();
      if (exp_t(0, pa, md, de, pw | mvv) == TGT_EXTERNAL)
        q.push_back(0);
      if (exp_t(1, xa, md, de, 0) == TGT_EXTERNAL)
        q.push_back(1);
      if (exp_t(2, ya, md, de, 0) == TGT_EXTERNAL)
        q.push_back(2);
      chk("ext_valid", er.valid, q.size() > 0);
      if (q.size() > 0)
      begin
        chk("ext_space", er.space, q[0]);
        chk("ext_addr", er.addr, (q[0] == 0) ? pa : (q[0] == 1) ? xa : ya);
        chk("ext_write", er.write, (q[0] == 0) ? (pw | mvv) : (q[0] == 1) ? xw : yw);
      end
      chk("vector_fetch", vf, pa <= 'h003F);
      chk("mode1_rom", m1, 0);
      chk("irq_first", irq1, nl);
      chk("irq_second", irq2, nh);
    end
    $display("test decode done");
    complete_run();
  end
endmodule : memory_map_mode_decoder_tb
